// ### logic/pcb_pkg.sv
package pcb_pkg;

   // clock and timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int PHASE_TOL_NS    = 30;
   localparam int PHASE_TOL_CYC   = (PHASE_TOL_NS / CLK_PERIOD_NS < 1) ? 1 : PHASE_TOL_NS / CLK_PERIOD_NS;
   localparam int LOCK_LOSS_ERRS  = 4;
   localparam int LOCK_GAIN_GOOD  = 32;
   localparam int PARK_MAX_CYC    = 6;
   localparam int TEST_RST_EDGES  = 5;
   localparam int WDOG_REF_EDGES  = 64;
   localparam int SYNC_STAGES     = 2;

   // register offsets (byte addresses)
   localparam logic [11:0] REG_CTRL     = 12'h000;
   localparam logic [11:0] REG_STATUS   = 12'h004;
   localparam logic [11:0] REG_IRQ_STAT = 12'h008;
   localparam logic [11:0] REG_IRQ_MASK = 12'h00C;

   // ctrl fields
   localparam int CTRL_SW_OFF_LSB = 0;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // status fields
   localparam int ST_LOCK_BIT    = 0;
   localparam int ST_REF_BIT     = 1;
   localparam int ST_TEST_BIT    = 2;
   localparam int ST_RATIO_LSB   = 4;
   localparam int ST_BANK1_LSB   = 8;
   localparam int ST_BANK2_LSB   = 12;
   localparam int ST_FS_LSB      = 16;

   // interrupt fields
   localparam int IRQ_LOCK_GAIN  = 0;
   localparam int IRQ_LOCK_LOSS  = 1;
   localparam int IRQ_BANK1_OFF  = 2;
   localparam int IRQ_BANK2_OFF  = 3;
   localparam int IRQ_W          = 4;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

   // three-level pin decode, one-hot
   typedef enum logic [2:0] {
      LVL_LOW  = 3'b001,
      LVL_MID  = 3'b010,
      LVL_HIGH = 3'b100
   } pcb_lvl_t;

   // per-bank output state
   typedef enum logic [3:0] {
      BANK_RUN     = 4'b0001,
      BANK_PARKING = 4'b0010,
      BANK_PARKED  = 4'b0100,
      BANK_HIZ     = 4'b1000
   } pcb_bank_st_t;

   typedef enum logic [1:0] {
      LK_ACQUIRE = 2'b01,
      LK_LOCKED  = 2'b10
   } pcb_lock_st_t;

   // one output bank: four clock pins with their enables
   typedef struct packed {
      logic [3:0] q;
      logic [3:0] oe;
   } pcb_bank_pins_t;

   // feedback divide from the two selector levels
   function automatic logic [3:0] pcb_fb_ratio(input pcb_lvl_t s1, input pcb_lvl_t s0);
      logic [3:0] r;
      r = 4'h1;
      case (s1)
         LVL_LOW:  r = (s0 == LVL_LOW) ? 4'h1 : (s0 == LVL_MID) ? 4'h2 : 4'h3;
         LVL_MID:  r = (s0 == LVL_LOW) ? 4'h4 : (s0 == LVL_MID) ? 4'h5 : 4'h6;
         LVL_HIGH: r = (s0 == LVL_LOW) ? 4'h8 : (s0 == LVL_MID) ? 4'hA : 4'hC;
         default:  r = 4'h1;
      endcase
      return r;
   endfunction

endpackage

// ### logic/pcb_trilevel.sv
`timescale 1ns/1ps
// decodes one three-level strap from its two pad comparators
module pcb_trilevel
   import pcb_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // pad comparators
   input  wire logic above_hi,
   input  wire logic below_lo,
   // decoded level
   output pcb_lvl_t  level
);

   logic [SYNC_STAGES-1:0] hi_sync_ff;
   logic [SYNC_STAGES-1:0] lo_sync_ff;
   pcb_lvl_t               level_ff;
   pcb_lvl_t               nxt_level;

   // two-flop synchronisers; only the last stage is decoded
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hi_sync_ff <= '0;
         lo_sync_ff <= '0;
      end
      else
      begin
         hi_sync_ff <= {hi_sync_ff[SYNC_STAGES-2:0], above_hi};
         lo_sync_ff <= {lo_sync_ff[SYNC_STAGES-2:0], below_lo};
      end
   end

   // neither comparator tripped means the pad floats at mid-supply
   always_comb
   begin
      if (hi_sync_ff[SYNC_STAGES-1] && !lo_sync_ff[SYNC_STAGES-1])
         nxt_level = LVL_HIGH;                                    // [RULE11]
      else if (lo_sync_ff[SYNC_STAGES-1] && !hi_sync_ff[SYNC_STAGES-1])
         nxt_level = LVL_LOW;                                     // [RULE11]
      else
         nxt_level = LVL_MID;                                     // [RULE11]
   end

   // open pad reads as mid until the first samples arrive
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         level_ff <= LVL_MID;
      else
         level_ff <= nxt_level;
   end

   assign level = level_ff;

endmodule

// ### logic/pcb_clock_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1: chooser low picks first pair, high second
// RULE2: unconnected chooser reads low, first pair
// RULE3: each bank-off input stops its own bank
// RULE4: bank-off low keeps bank outputs toggling
// RULE5: unconnected bank-off reads low, bank runs
// RULE6: settled flag high when locked, else low
// RULE7: style selector high: disabled bank floats
// RULE8: style selector low: disabled bank parks low
// RULE9: style selector mid enters factory test
// RULE10: two selectors set feedback output divide
// RULE11: three-level pins decode high, low, open-mid
// RULE12: board straps range selector to band
// RULE13: park low on falling edge; float at once
// RULE14: four errored feedback cycles drop settled flag
// RULE15: 32 clean feedback cycles raise settled flag
// RULE16: nine feedback ratios; banks always divide one
// RULE17: bank-off inputs synchronised before stop logic
module pcb_clock_ctrl
   import pcb_pkg::*;
#(
   parameter int LOSS_ERRS = LOCK_LOSS_ERRS,
   parameter int GAIN_GOOD = LOCK_GAIN_GOOD,
   parameter int WDOG_REFS = WDOG_REF_EDGES
)
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // reference and loop pins
   input  wire logic [1:0]  first_ref_pair,
   input  wire logic [1:0]  second_ref_pair,
   input  wire logic        ref_chooser,
   input  wire logic        feedback_clock_in,
   input  wire logic        vco_clk_in,
   // three-level straps as pad comparator pairs: fs, fbds0, fbds1, output mode
   input  wire logic [3:0]  strap_above_hi,
   input  wire logic [3:0]  strap_below_lo,
   // bank control pins
   input  wire logic [1:0]  bank_off_inputs,
   // clock outputs
   output pcb_bank_pins_t   bank1_pins,
   output pcb_bank_pins_t   bank2_pins,
   output logic      [1:0]  feedback_clock_outputs,
   output logic      [1:0]  feedback_clock_oe,
   output logic             pll_ref_clk,
   // status
   output logic             settled,
   output logic             irq
);

   localparam int NPIN = 6;

   pcb_lvl_t            strap_lvl [4];
   logic [NPIN-1:0]     pin_s1_ff;
   logic [NPIN-1:0]     pin_s2_ff;
   logic                ref_sel;
   logic                ref_lvl;
   logic                fb_lvl;
   logic                vco_lvl;
   logic [1:0]          off_sync;
   logic                ref_d_ff;
   logic                fb_d_ff;
   logic                vco_d_ff;
   logic                ref_rise;
   logic                fb_rise;
   logic                vco_rise;
   logic                test_mode;
   logic                test_hold;
   logic [3:0]          ratio;
   logic [3:0]          div_cnt_ff;
   logic                fb_div_ff;
   logic                pll_lvl;
   logic [1:0]          ctrl_ff;
   logic [IRQ_W-1:0]    irq_stat_ff;
   logic [IRQ_W-1:0]    irq_mask_ff;
   logic [IRQ_W-1:0]    irq_evt;
   logic [31:0]         prdata_ff;
   logic                pslverr_ff;
   logic                wr_acc;
   logic                addr_ok;
   logic [31:0]         status_word;
   pcb_lock_st_t        lock_st_ff;
   logic [7:0]          since_ref_ff;
   logic [7:0]          err_run_ff;
   logic [7:0]          ok_run_ff;
   logic [7:0]          wdog_ff;
   logic [2:0]          test_edges_ff;
   logic                phase_err;
   pcb_bank_st_t        bank_st_ff [2];
   logic [3:0]          bank_q_ff [2];
   logic [1:0]          parked_evt;

   // straps: fs, fbds0, fbds1, output mode
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_strap
         pcb_trilevel u_lvl
         (
            .sys_clk  (sys_clk),
            .rst_n    (rst_n),
            .above_hi (strap_above_hi[gi]),
            .below_lo (strap_below_lo[gi]),
            .level    (strap_lvl[gi])
         );
      end
   endgenerate

   // two-flop synchronisers on all digital pins; reset low models the pad pull-downs
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_ff <= '0;                                         // [RULE2] [RULE5]
         pin_s2_ff <= '0;
      end
      else
      begin
         pin_s1_ff <= {bank_off_inputs, ref_chooser, second_ref_pair[1], feedback_clock_in, vco_clk_in};
         pin_s2_ff <= pin_s1_ff;
      end
   end

   assign vco_lvl  = pin_s2_ff[0];
   assign fb_lvl   = pin_s2_ff[1];
   assign ref_sel  = pin_s2_ff[3];
   assign off_sync = pin_s2_ff[5:4] | ctrl_ff;                    // [RULE17]

   // reference pair choice, true side of the selected pair
   logic ref_a_s1_ff;
   logic ref_a_s2_ff;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ref_a_s1_ff <= 1'b0;
         ref_a_s2_ff <= 1'b0;
      end
      else
      begin
         ref_a_s1_ff <= first_ref_pair[1];
         ref_a_s2_ff <= ref_a_s1_ff;
      end
   end
   assign ref_lvl     = ref_sel ? pin_s2_ff[2] : ref_a_s2_ff;     // [RULE1]
   assign pll_ref_clk = ref_lvl;

   // edge detection on synchronised levels only
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ref_d_ff <= 1'b0;
         fb_d_ff  <= 1'b0;
         vco_d_ff <= 1'b0;
      end
      else
      begin
         ref_d_ff <= ref_lvl;
         fb_d_ff  <= fb_lvl;
         vco_d_ff <= pll_lvl;
      end
   end
   assign ref_rise = ref_lvl & ~ref_d_ff;
   assign fb_rise  = fb_lvl & ~fb_d_ff;
   assign vco_rise = pll_lvl & ~vco_d_ff;

   // mid on the style selector bypasses the loop with the reference level
   assign test_mode = (strap_lvl[3] == LVL_MID);                  // [RULE9]
   assign pll_lvl   = test_mode ? ref_lvl : vco_lvl;
   assign test_hold = test_mode & off_sync[1];

   // test reset: five reference edges with bank 2 off park the divider and lock counters
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         test_edges_ff <= 3'h0;
      else if (!test_hold)
         test_edges_ff <= 3'h0;
      else if (ref_rise && test_edges_ff != 3'(TEST_RST_EDGES))
         test_edges_ff <= test_edges_ff + 3'h1;
   end

   // feedback divider; banks themselves always run undivided
   assign ratio = pcb_fb_ratio(strap_lvl[2], strap_lvl[1]);       // [RULE10] [RULE16]
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_cnt_ff <= 4'h0;
         fb_div_ff  <= 1'b0;
      end
      else if (test_edges_ff == 3'(TEST_RST_EDGES))
      begin
         div_cnt_ff <= 4'h0;
         fb_div_ff  <= 1'b0;
      end
      else if (ratio == 4'h1)
         fb_div_ff <= pll_lvl;                                    // [RULE16]
      else if (vco_rise)
      begin
         div_cnt_ff <= (div_cnt_ff >= ratio - 4'h1) ? 4'h0 : div_cnt_ff + 4'h1;
         fb_div_ff  <= (div_cnt_ff >= ratio - 4'h1) || (div_cnt_ff < (ratio >> 1) - 4'h1) ||
                       (ratio == 4'h2 && div_cnt_ff == 4'h1) ? 1'b1 : 1'b0;
      end
   end
   assign feedback_clock_outputs = {fb_div_ff, fb_div_ff};
   assign feedback_clock_oe      = {2{~test_hold}};

   // phase check: a feedback edge far from the last reference edge is an error
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         since_ref_ff <= 8'hFF;
      else if (ref_rise)
         since_ref_ff <= 8'h0;
      else if (since_ref_ff != 8'hFF)
         since_ref_ff <= since_ref_ff + 8'h1;
   end
   assign phase_err = (since_ref_ff > 8'(PHASE_TOL_CYC)) && !ref_rise;

   // lock detector with feedback watchdog counted in reference edges
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lock_st_ff <= LK_ACQUIRE;
         err_run_ff <= 8'h0;
         ok_run_ff  <= 8'h0;
         wdog_ff    <= 8'h0;
      end
      else if (test_edges_ff == 3'(TEST_RST_EDGES))
      begin
         lock_st_ff <= LK_ACQUIRE;
         err_run_ff <= 8'h0;
         ok_run_ff  <= 8'h0;
         wdog_ff    <= 8'h0;
      end
      else
      begin
         if (fb_rise)
            wdog_ff <= 8'h0;
         else if (ref_rise && wdog_ff != 8'(WDOG_REFS))
            wdog_ff <= wdog_ff + 8'h1;
         case (lock_st_ff)
            LK_ACQUIRE:
            begin
               if (fb_rise)
               begin
                  ok_run_ff <= phase_err ? 8'h0 : ok_run_ff + 8'h1;
                  if (!phase_err && ok_run_ff == 8'(GAIN_GOOD - 1))
                  begin
                     lock_st_ff <= LK_LOCKED;                     // [RULE15]
                     err_run_ff <= 8'h0;
                  end
               end
            end
            LK_LOCKED:
            begin
               if (wdog_ff == 8'(WDOG_REFS))
               begin
                  lock_st_ff <= LK_ACQUIRE;
                  ok_run_ff  <= 8'h0;
               end
               else if (fb_rise)
               begin
                  err_run_ff <= phase_err ? err_run_ff + 8'h1 : 8'h0;
                  if (phase_err && err_run_ff == 8'(LOSS_ERRS - 1))
                  begin
                     lock_st_ff <= LK_ACQUIRE;                    // [RULE14]
                     ok_run_ff  <= 8'h0;
                  end
               end
            end
            default:
               lock_st_ff <= LK_ACQUIRE;
         endcase
      end
   end
   assign settled = (lock_st_ff == LK_LOCKED);                    // [RULE6]

   // per-bank stop logic; parking waits for the clock to be low so no pulse is cut
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_bank
         always_ff @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               bank_st_ff[gi] <= BANK_RUN;
               bank_q_ff[gi]  <= 4'h0;
            end
            else
            begin
               case (bank_st_ff[gi])
                  BANK_RUN:
                  begin
                     bank_q_ff[gi] <= {4{pll_lvl}};               // [RULE4] [RULE16]
                     if (off_sync[gi] && !test_mode && strap_lvl[3] == LVL_HIGH)
                        bank_st_ff[gi] <= BANK_HIZ;               // [RULE3] [RULE7]
                     else if (off_sync[gi] && !test_mode)
                        bank_st_ff[gi] <= BANK_PARKING;           // [RULE3] [RULE8]
                  end
                  BANK_PARKING:
                  begin
                     if (!pll_lvl)
                     begin
                        bank_q_ff[gi]  <= 4'h0;                   // [RULE13]
                        bank_st_ff[gi] <= BANK_PARKED;
                     end
                     else
                        bank_q_ff[gi] <= 4'hF;
                  end
                  BANK_PARKED:
                  begin
                     bank_q_ff[gi] <= 4'h0;
                     if (!off_sync[gi] || test_mode)
                        bank_st_ff[gi] <= BANK_RUN;
                  end
                  BANK_HIZ:
                  begin
                     bank_q_ff[gi] <= {4{pll_lvl}};
                     if (!off_sync[gi] || test_mode)
                        bank_st_ff[gi] <= BANK_RUN;
                  end
                  default:
                     bank_st_ff[gi] <= BANK_RUN;
               endcase
            end
         end
         assign parked_evt[gi] = (bank_st_ff[gi] == BANK_PARKING) && !pll_lvl;
      end
   endgenerate

   // float at once when style is high; bank 2 off in test mode floats both banks and the feedback pair
   always_comb
   begin
      bank1_pins.q  = bank_q_ff[0];
      bank2_pins.q  = bank_q_ff[1];
      bank1_pins.oe = {4{bank_st_ff[0] != BANK_HIZ && !test_hold}};  // [RULE7] [RULE13]
      bank2_pins.oe = {4{bank_st_ff[1] != BANK_HIZ && !test_hold}};
   end

   // apb: zero wait states, read data captured in the setup cycle
   assign wr_acc  = psel & penable & pwrite;
   assign addr_ok = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_IRQ_STAT) ||
                    (paddr == REG_IRQ_MASK);
   assign pready  = 1'b1;
   assign prdata  = prdata_ff;
   assign pslverr = pslverr_ff & psel & penable;

   assign status_word = {12'h0, strap_lvl[0], 1'b0, bank_st_ff[1], bank_st_ff[0], ratio,
                         1'b0, test_mode, ref_sel, settled};

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata_ff  <= 32'h0;
         pslverr_ff <= 1'b0;
      end
      else if (psel && !penable)
      begin
         pslverr_ff <= !addr_ok;
         if (paddr == REG_CTRL)
            prdata_ff <= {30'h0, ctrl_ff};
         else if (paddr == REG_STATUS)
            prdata_ff <= status_word;
         else if (paddr == REG_IRQ_STAT)
            prdata_ff <= {28'h0, irq_stat_ff};
         else if (paddr == REG_IRQ_MASK)
            prdata_ff <= {28'h0, irq_mask_ff};
         else
            prdata_ff <= 32'h0;
      end
   end

   // software bank-off bits act like the pins, through the same stop logic
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_ff     <= CTRL_RESET;
         irq_mask_ff <= IRQ_MASK_RESET;
      end
      else if (wr_acc)
      begin
         if (paddr == REG_CTRL)
            ctrl_ff <= pwdata[CTRL_SW_OFF_LSB +: 2];
         else if (paddr == REG_IRQ_MASK)
            irq_mask_ff <= pwdata[IRQ_W-1:0];
      end
   end

   // sticky events; a new event wins over a write-one clear in the same cycle
   logic lock_d_ff;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         lock_d_ff <= 1'b0;
      else
         lock_d_ff <= settled;
   end
   assign irq_evt = {parked_evt, ~settled & lock_d_ff, settled & ~lock_d_ff};

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_stat_ff <= '0;
      else if (wr_acc && paddr == REG_IRQ_STAT)
         irq_stat_ff <= (irq_stat_ff & ~pwdata[IRQ_W-1:0]) | irq_evt;
      else
         irq_stat_ff <= irq_stat_ff | irq_evt;
   end
   assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule

// ### verif/pcb_asserts.sv
`timescale 1ns/1ps
// pin-level checks on the clock controller
module pcb_asserts
   import pcb_pkg::*;
#(
   parameter int GAIN_GOOD = LOCK_GAIN_GOOD
)
(
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rst_n,
   // bus handshake
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pslverr,
   // pins in
   input wire logic [1:0] first_ref_pair,
   input wire logic [1:0] second_ref_pair,
   input wire logic       ref_chooser,
   input wire logic       feedback_clock_in,
   input wire logic [3:0] strap_above_hi,
   input wire logic [3:0] strap_below_lo,
   input wire logic [1:0] bank_off_inputs,
   // pins out
   input pcb_bank_pins_t  bank1_pins,
   input pcb_bank_pins_t  bank2_pins,
   input wire logic [1:0] feedback_clock_outputs,
   input wire logic       pll_ref_clk,
   input wire logic       settled
);
   // style strap decode; both comparators or neither read as mid
   wire        style_hi  = strap_above_hi[3] & ~strap_below_lo[3];
   wire        style_lo  = strap_below_lo[3] & ~strap_above_hi[3];
   wire        style_mid = ~style_hi & ~style_lo;
   wire        sel_ref   = ref_chooser ? second_ref_pair[1] : first_ref_pair[1];
   logic       fb_ff;
   logic [7:0] gain_cnt_ff;

   // feedback edges seen while unsettled: an upper bound, since the design sees them later
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fb_ff       <= 1'b0;
         gain_cnt_ff <= 8'h00;
      end
      else
      begin
         fb_ff <= feedback_clock_in;
         if (settled)
            gain_cnt_ff <= 8'h00;
         else if (feedback_clock_in && !fb_ff && gain_cnt_ff != 8'hFF)
            gain_cnt_ff <= gain_cnt_ff + 8'h01;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence ref_steady_s;
      ($stable(ref_chooser) && $stable(sel_ref)) [*5];
   endsequence
   sequence off1_float_s;
      (bank_off_inputs[0] && style_hi) [*8];
   endsequence
   sequence off2_park_s;
      (bank_off_inputs[1] && style_lo) [*8];
   endsequence

   ref_route_a:
      assert property (ref_steady_s |-> pll_ref_clk == sel_ref) else $error("reference not from chosen pair");
   hiz_float_a:
      assert property (off1_float_s |-> bank1_pins.oe == 4'h0) else $error("bank1 not floated");
   bank_run_a:
      assert property ((!bank_off_inputs[0] && !style_mid) [*8] |-> bank1_pins.oe == 4'hF)
         else $error("bank1 not driven");
   park_low_a:
      assert property (off2_park_s |-> ##[0:60] (bank2_pins.q == 4'h0 && bank2_pins.oe == 4'hF))
         else $error("bank2 not parked low");
   test_ignore_a:
      assert property ((style_mid && bank_off_inputs[0] && !bank_off_inputs[1]) [*8] |-> bank1_pins.oe == 4'hF)
         else $error("bank-off acted in test mode");
   lock_gain_a:
      assert property ($rose(settled) |-> gain_cnt_ff >= GAIN_GOOD) else $error("settled too early");
   fb_pair_a:
      assert property (feedback_clock_outputs[0] == feedback_clock_outputs[1]) else $error("feedback pair split");
   slverr_phase_a:
      assert property (pslverr |-> psel && penable) else $error("error outside access phase");
endmodule

bind pcb_clock_ctrl pcb_asserts #(.GAIN_GOOD(GAIN_GOOD)) u_asserts (.*);

// ### verif/pcb_board_model.sv
`timescale 1ns/1ps
// board side: free-running reference source and the returning feedback clock
module pcb_board_model #(
   parameter int HALF = 8
)
(
   // clock
   input wire logic sys_clk,
   // fault control: feedback lags by six cycles, beyond the phase window
   input wire logic fb_err,
   // pins towards the controller
   output logic [1:0] first_ref_pair,
   output logic [1:0] second_ref_pair,
   output logic       vco_clk_in,
   output logic       feedback_clock_in
);
   logic [3:0] cnt  = 4'h0;
   logic       wave = 1'b0;
   logic [7:0] dly  = 8'h00;

   // square wave, kept slow so the sampled vco level has clean edges
   always @(posedge sys_clk)
   begin
      cnt <= (cnt == 4'(HALF - 1)) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'(HALF - 1))
         wave <= ~wave;
      dly <= {dly[6:0], wave};
   end

   // the two pairs carry opposite phases so a wrong choice shows
   assign first_ref_pair    = {wave, ~wave};
   assign second_ref_pair   = {~wave, wave};
   assign vco_clk_in        = wave;
   assign feedback_clock_in = fb_err ? dly[5] : wave;
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
// self-checking bench for the clock controller
module tb
   import pcb_pkg::*;
;
   logic           sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic           ref_chooser, fb_err, feedback_clock_in, vco_clk_in, pll_ref_clk, settled, irq;
   logic [11:0]    paddr;
   logic [31:0]    pwdata, prdata, rd, err;
   logic [1:0]     first_ref_pair, second_ref_pair, bank_off_inputs, feedback_clock_outputs, feedback_clock_oe;
   logic [3:0]     strap_above_hi, strap_below_lo;
   pcb_bank_pins_t bank1_pins, bank2_pins;
   int             mismatches = 0;
   int             checks = 0;
   int             cyc_cnt = 0;
   int             p;
   int             rt [9] = '{1, 2, 3, 4, 5, 6, 8, 10, 12};

   pcb_clock_ctrl DUT (.*);
   pcb_board_model u_board (.*);

   // 100 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // hang guard; the run needs under 10k cycles
   always @(posedge sys_clk)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 40000)
      begin
         mismatches++;
         close_out();
      end
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task chk1(input logic seen, input logic exp);
      chk({31'h0, seen}, {31'h0, exp});
   endtask

   task close_out();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // one apb transfer, entered just after a rising edge; leaves one idle cycle
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      rd = prdata;
      err = {31'h0, pslverr};
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   // straps: 0 low, 1 open, 2 high
   task set_st(input int fs, input int d0, input int d1, input int md);
      strap_above_hi <= {md == 2, d1 == 2, d0 == 2, fs == 2};
      strap_below_lo <= {md == 0, d1 == 0, d0 == 0, fs == 0};
   endtask

   task wait_lock(input logic v);
      for (int i = 0; i < 2000 && settled !== v; i++)
         @(posedge sys_clk);
   endtask

   // full period of the feedback output in clock cycles
   task per(output int n);
      for (int i = 0; i < 400 && feedback_clock_outputs[0] !== 1'b0; i++) @(posedge sys_clk);
      for (int i = 0; i < 400 && feedback_clock_outputs[0] !== 1'b1; i++) @(posedge sys_clk);
      for (n = 0; n < 400 && feedback_clock_outputs[0] !== 1'b0; n++) @(posedge sys_clk);
      for (; n < 800 && feedback_clock_outputs[0] !== 1'b1; n++) @(posedge sys_clk);
   endtask

   // main sequence
   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      ref_chooser = 1'b0;
      fb_err = 1'b0;
      bank_off_inputs = 2'h0;
      strap_above_hi = 4'h8; // range strapped low for the slow band
      strap_below_lo = 4'h7;
      cyc(4);
      rst_n <= 1'b1;
      cyc(4);
      apb(0, REG_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(0, REG_STATUS, 32'h0);
      chk(rd & 32'h000E00F0, 32'h00020010);
      apb(0, 12'h010, 32'h0);
      chk(err, 32'h1);
      apb(1, REG_IRQ_MASK, 32'hF);
      apb(0, REG_IRQ_MASK, 32'h0);
      chk(rd, 32'hF);
      wait_lock(1'b1);
      chk1(settled, 1'b1);
      cyc(1);
      chk1(irq, 1'b1);
      apb(1, REG_IRQ_STAT, 32'hF);
      chk1(irq, 1'b0);
      // a burst shorter than the loss count must not drop the flag
      fb_err <= 1'b1;
      cyc(24);
      fb_err <= 1'b0;
      cyc(40);
      chk1(settled, 1'b1);
      fb_err <= 1'b1;
      wait_lock(1'b0);
      chk1(settled, 1'b0);
      fb_err <= 1'b0;
      wait_lock(1'b1);
      chk1(settled, 1'b1);
      for (int k = 0; k < 9; k++)
      begin
         set_st(0, k % 3, k / 3, 2);
         cyc(40);
         per(p);
         chk(p, rt[k] * 16);
         apb(0, REG_STATUS, 32'h0);
         chk(rd & 32'hF0, rt[k] << 4);
      end
      set_st(0, 0, 0, 2);
      bank_off_inputs <= 2'h1;
      cyc(12);
      chk({22'h0, feedback_clock_oe, bank2_pins.oe, bank1_pins.oe}, 32'h3F0);
      apb(0, REG_STATUS, 32'h0);
      chk(rd & 32'hFF00, 32'h1800);
      bank_off_inputs <= 2'h0;
      cyc(12);
      chk({24'h0, bank2_pins.oe, bank1_pins.oe}, 32'hFF);
      set_st(0, 0, 0, 0);
      apb(1, REG_IRQ_MASK, 32'h0);
      apb(1, REG_IRQ_STAT, 32'hF);
      bank_off_inputs <= 2'h2;
      cyc(70);
      chk({24'h0, bank2_pins}, 32'h0F);
      chk1(irq, 1'b0);
      apb(0, REG_STATUS, 32'h0);
      chk(rd & 32'hF000, 32'h4000);
      apb(1, REG_IRQ_MASK, 32'h8);
      chk1(irq, 1'b1);
      apb(1, REG_IRQ_STAT, 32'h8);
      chk1(irq, 1'b0);
      bank_off_inputs <= 2'h0;
      cyc(12);
      set_st(0, 0, 0, 1);
      bank_off_inputs <= 2'h1;
      cyc(12);
      chk({28'h0, bank1_pins.oe}, 32'hF);
      apb(0, REG_STATUS, 32'h0);
      chk(rd & 32'h4, 32'h4);
      bank_off_inputs <= 2'h0;
      set_st(0, 0, 0, 2);
      cyc(6);
      ref_chooser <= 1'b1;
      cyc(6);
      apb(0, REG_STATUS, 32'h0);
      chk(rd & 32'h2, 32'h2);
      ref_chooser <= 1'b0;
      cyc(6);
      apb(0, REG_STATUS, 32'h0);
      chk(rd & 32'h2, 32'h0);
      close_out();
   end
endmodule
